// file: qlec_consts.svh
// Purpose: register map, field positions and reset values of the QAM loop/equalizer control bank
// Assumes: one APB word per register, byte address = index * 4
// Notes: indices keep the byte-register numbering of the demodulator map
// Contract
// - coarse_baud_offset is a 12-bit signed read-only word, ppm = 1e6 * value / 4096.
// - baud scan release: 00 frozen, 01 analog AGC lock, 10 all AGC lock.
// - timing loop release bits 3:2: 00 frozen, 01 analog, 10 all AGC, 11 baud lock.
// - sweep starts at signed 100 * start / 256 percent of symbol rate, default FAh.
// - sweep spans +/- 100 * 7-bit span / 256 percent, default 1Ch.
// - sweep adds signed step 100 * increment / 2^24 percent each symbol, default 03h.
// - sweep_freq_offset is 16-bit signed read-only, Hz = front_end_clock * value / 2^16.
// - acquisition carrier gains: 4-bit proportional 0110, 5-bit integral 1Dh, both signed.
// - tracking carrier gains: 4-bit proportional 0101, 5-bit integral 1Eh, both signed.
// - demod_locked_flag bit 0 reads 0 unlocked and after reset, 1 locked.
// - phase_loop_freq_offset is 16-bit signed, Hz = symbol rate * value / 2^16.
// - feed-forward equalizer has 1 + 2 * half length taps, 7-bit field default 0Ah.
// - blind gain code 0 = auto 16, codes 1..8 = 1..128, others reserved.
// - decision forward gain bits 7:4 same coding, code 0 = auto 8.
// - decision feedback gain bits 3:0 same coding, code 0 = auto 8.
// - cable_cnr_metric is 24-bit unsigned, dB = 10 log(2^24 / value).
// - self-manage 1 sequences equalizer itself; 0 follows the manual command bus.
// - leaving full feedback: policy 0 clears feedback taps, policy 1 freezes them.
// - noise_power_estimate is 24-bit unsigned, C/N = 10 log(128 * ref / estimate).
// - constellation_ref_power is 14-bit unsigned reference power of chosen constellation.
// - writing 1 to acquisition_kick restarts terrestrial acquisition, bit returns to 0.
// - hier_layer_select 0 picks high-priority stream, 1 low-priority, default 0.
// - tps autoconfig off 0 uses TPS parameters, 1 uses manual parameter registers.
`ifndef QLEC_CONSTS_SVH
`define QLEC_CONSTS_SVH
`define QLEC_ADDR(ix) ({(ix), 2'b00})
`define QLEC_IX_COARSE 10'h214
`define QLEC_IX_RELEASE 10'h219
`define QLEC_IX_SW_START 10'h230
`define QLEC_IX_SW_SPAN 10'h231
`define QLEC_IX_SW_STEP 10'h232
`define QLEC_IX_SW_FREQ 10'h234
`define QLEC_IX_CARRIER_PROP_GAIN_ACQUIRE 10'h238
`define QLEC_IX_CARRIER_INTEG_GAIN_ACQUIRE 10'h239
`define QLEC_IX_KP_TRK 10'h23A
`define QLEC_IX_KI_TRK 10'h23B
`define QLEC_IX_LOCK 10'h23E
`define QLEC_IX_PH_FREQ 10'h240
`define QLEC_IX_HALF_LEN 10'h260
`define QLEC_IX_CENTER 10'h261
`define QLEC_IX_ADAPT 10'h264
`define QLEC_IX_DFE_GAIN 10'h265
`define QLEC_IX_CNR 10'h26C
`define QLEC_IX_EQ_AUTO 10'h278
`define QLEC_IX_NOISE 10'h2A4
`define QLEC_IX_REF_PWR 10'h2C0
`define QLEC_IX_KICK 10'h2E0
`define QLEC_IX_HIER 10'h2E4
`define QLEC_IX_TPS 10'h2E8
`define QLEC_RST_RELEASE 4'h8
`define QLEC_RST_SW_START 8'hFA
`define QLEC_RST_SW_SPAN 7'h1C
`define QLEC_RST_SW_STEP 6'h03
`define QLEC_RST_CARRIER_PROP_GAIN_ACQUIRE 4'h6
`define QLEC_RST_CARRIER_INTEG_GAIN_ACQUIRE 5'h1D
`define QLEC_RST_KP_TRK 4'h5
`define QLEC_RST_KI_TRK 5'h1E
`define QLEC_RST_HALF_LEN 7'h0A
`define QLEC_RST_CENTER 8'h0B
`define QLEC_RST_EQ_AUTO 2'h3
`define QLEC_AUTO_BLIND 8'h10
`define QLEC_AUTO_DD 8'h08
`define QLEC_BIT_TIM_LO 2
`define QLEC_BIT_POLICY 1
`define QLEC_BIT_SELF 0
`endif

// file: qlec_pkg.sv
// Purpose: shared types of the QAM loop/equalizer control bank
// Assumes: core status arrives on pclk
// Notes: none
`default_nettype none
package qlec_pkg;
  typedef enum logic [1:0] {
    QLEC_EQ_BLIND = 2'b00,
    QLEC_EQ_DD = 2'b01,
    QLEC_EQ_FULL = 2'b10
  } qlec_eq_state_e;
  typedef struct packed {
    logic dd_mode;
    logic init_ffe;
    logic freeze_ffe;
    logic init_dfe;
    logic freeze_dfe;
  } qlec_eq_cmd_s;
  typedef struct packed {
    logic agc_analog_lock;
    logic agc_all_lock;
    logic baud_loop_lock;
    logic eq_blind_conv;
    logic demod_locked;
    logic meas_update;
    logic [11:0] coarse_baud;
    logic [15:0] sweep_freq;
    logic [15:0] phase_freq;
    logic [23:0] cnr;
    logic [23:0] noise;
    logic [13:0] ref_power;
  } qlec_core_stat_s;
  typedef struct packed {
    logic baud_scan_run;
    logic timing_loop_run;
    logic [7:0] sweep_start;
    logic [6:0] sweep_span;
    logic [5:0] sweep_step;
    logic [3:0] prop_gain;
    logic [4:0] integ_gain;
    logic [7:0] ffe_taps;
    logic [7:0] center_tap;
    logic [7:0] blind_gain;
    logic [7:0] dd_ffe_gain;
    logic [7:0] dd_dfe_gain;
    logic hier_lp;
    logic tps_manual;
  } qlec_cfg_s;
endpackage
`default_nettype wire

// file: qlec_regs.sv
// Purpose: APB register bank steering the QAM carrier, timing and equalizer loops
// Assumes: demodulator core runs on pclk, so status needs no synchroniser
// Notes: one wait state on every access so read data leaves a flip-flop
//
// Decided for this implementation: the APB slave port.
`include "qlec_consts.svh"
`default_nettype none
module qlec_regs
  import qlec_pkg::*;
#(
  parameter int AW = 12
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire qlec_core_stat_s core_stat,
  input wire qlec_eq_cmd_s eq_manual_bus,
  output qlec_cfg_s loop_cfg,
  output qlec_eq_cmd_s eq_cmd,
  output logic acq_restart
);

  if (AW < 12)
  begin : g_bad_aw
    $error("qlec_regs: AW must be at least 12");
  end

  logic ack;
  logic [3:0] release_sel;
  logic [7:0] sweep_start;
  logic [6:0] sweep_span;
  logic [5:0] sweep_step;
  logic [3:0] kp_acquire;
  logic [4:0] ki_acquire;
  logic [3:0] kp_track;
  logic [4:0] ki_track;
  logic [6:0] half_len;
  logic [7:0] center_tap;
  logic [7:0] adapt_gains;
  logic [3:0] dfe_gain;
  logic [1:0] eq_auto;
  logic hier_lp;
  logic tps_manual;
  logic [11:0] m_coarse;
  logic [15:0] m_sweep;
  logic [15:0] m_phase;
  logic [23:0] m_cnr;
  logic [23:0] m_noise;
  logic [13:0] m_ref;
  logic m_locked;
  qlec_eq_state_e eq_state;
  qlec_eq_state_e next_eq_state;
  qlec_cfg_s next_cfg;
  qlec_eq_cmd_s next_eq_cmd;

  // bus decode
  wire access = psel & penable;
  wire commit = access & ack;
  wire wr = commit & pwrite;
  wire [11:0] a = paddr[11:0];
  wire hi_zero = (AW == 12) ? 1'b1 : ~|(paddr >> 12);
  wire s_coarse = hi_zero & (a == `QLEC_ADDR(`QLEC_IX_COARSE));
  wire s_release = hi_zero & (a == `QLEC_ADDR(`QLEC_IX_RELEASE));
  wire s_sw_start = hi_zero & (a == `QLEC_ADDR(`QLEC_IX_SW_START));
  wire s_sw_span = hi_zero & (a == `QLEC_ADDR(`QLEC_IX_SW_SPAN));
  wire s_sw_step = hi_zero & (a == `QLEC_ADDR(`QLEC_IX_SW_STEP));
  wire s_sw_freq = hi_zero & (a == `QLEC_ADDR(`QLEC_IX_SW_FREQ));
  wire s_carrier_prop_gain_acquire = hi_zero & (a == `QLEC_ADDR(`QLEC_IX_CARRIER_PROP_GAIN_ACQUIRE));
  wire s_carrier_integ_gain_acquire = hi_zero & (a == `QLEC_ADDR(`QLEC_IX_CARRIER_INTEG_GAIN_ACQUIRE));
  wire s_kp_trk = hi_zero & (a == `QLEC_ADDR(`QLEC_IX_KP_TRK));
  wire s_ki_trk = hi_zero & (a == `QLEC_ADDR(`QLEC_IX_KI_TRK));
  wire s_lock = hi_zero & (a == `QLEC_ADDR(`QLEC_IX_LOCK));
  wire s_ph_freq = hi_zero & (a == `QLEC_ADDR(`QLEC_IX_PH_FREQ));
  wire s_half_len = hi_zero & (a == `QLEC_ADDR(`QLEC_IX_HALF_LEN));
  wire s_center = hi_zero & (a == `QLEC_ADDR(`QLEC_IX_CENTER));
  wire s_adapt = hi_zero & (a == `QLEC_ADDR(`QLEC_IX_ADAPT));
  wire s_dfe_gain = hi_zero & (a == `QLEC_ADDR(`QLEC_IX_DFE_GAIN));
  wire s_cnr = hi_zero & (a == `QLEC_ADDR(`QLEC_IX_CNR));
  wire s_eq_auto = hi_zero & (a == `QLEC_ADDR(`QLEC_IX_EQ_AUTO));
  wire s_noise = hi_zero & (a == `QLEC_ADDR(`QLEC_IX_NOISE));
  wire s_ref = hi_zero & (a == `QLEC_ADDR(`QLEC_IX_REF_PWR));
  wire s_kick = hi_zero & (a == `QLEC_ADDR(`QLEC_IX_KICK));
  wire s_hier = hi_zero & (a == `QLEC_ADDR(`QLEC_IX_HIER));
  wire s_tps = hi_zero & (a == `QLEC_ADDR(`QLEC_IX_TPS));
  wire mapped = s_coarse | s_release | s_sw_start | s_sw_span | s_sw_step | s_sw_freq
    | s_carrier_prop_gain_acquire | s_carrier_integ_gain_acquire | s_kp_trk | s_ki_trk | s_lock | s_ph_freq | s_half_len
    | s_center | s_adapt | s_dfe_gain | s_cnr | s_eq_auto | s_noise | s_ref | s_kick
    | s_hier | s_tps;

  // read mux, narrow fields zero-extended; signed values keep raw bits
  wire [31:0] rd_mux =
    s_coarse ? {20'h00000, m_coarse} :
    s_release ? {28'h0000000, release_sel} :
    s_sw_start ? {24'h000000, sweep_start} :
    s_sw_span ? {25'h0, sweep_span} :
    s_sw_step ? {26'h0, sweep_step} :
    s_sw_freq ? {16'h0000, m_sweep} :
    s_carrier_prop_gain_acquire ? {28'h0000000, kp_acquire} :
    s_carrier_integ_gain_acquire ? {27'h0, ki_acquire} :
    s_kp_trk ? {28'h0000000, kp_track} :
    s_ki_trk ? {27'h0, ki_track} :
    s_lock ? {31'h0, m_locked} :
    s_ph_freq ? {16'h0000, m_phase} :
    s_half_len ? {25'h0, half_len} :
    s_center ? {24'h000000, center_tap} :
    s_adapt ? {24'h000000, adapt_gains} :
    s_dfe_gain ? {28'h0000000, dfe_gain} :
    s_cnr ? {8'h00, m_cnr} :
    s_eq_auto ? {30'h0, eq_auto} :
    s_noise ? {8'h00, m_noise} :
    s_ref ? {18'h0, m_ref} :
    s_hier ? {31'h0, hier_lp} :
    s_tps ? {31'h0, tps_manual} :
    32'h00000000;

  assign pready = commit;
  assign pslverr = commit & ~mapped;

  // first access cycle latches read data, second completes
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ack <= 1'b0;
      prdata <= 32'h00000000;
    end
    else
    begin
      ack <= access & ~ack;
      if (access & ~ack & ~pwrite)
      begin
        prdata <= rd_mux;
      end
    end
  end

  // software-written controls
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      release_sel <= `QLEC_RST_RELEASE;
      sweep_start <= `QLEC_RST_SW_START;
      sweep_span <= `QLEC_RST_SW_SPAN;
      sweep_step <= `QLEC_RST_SW_STEP;
      kp_acquire <= `QLEC_RST_CARRIER_PROP_GAIN_ACQUIRE;
      ki_acquire <= `QLEC_RST_CARRIER_INTEG_GAIN_ACQUIRE;
      kp_track <= `QLEC_RST_KP_TRK;
      ki_track <= `QLEC_RST_KI_TRK;
      half_len <= `QLEC_RST_HALF_LEN;
      center_tap <= `QLEC_RST_CENTER;
      adapt_gains <= 8'h00;
      dfe_gain <= 4'h0;
      eq_auto <= `QLEC_RST_EQ_AUTO;
      hier_lp <= 1'b0;
      tps_manual <= 1'b0;
    end
    else if (wr)
    begin
      if (s_release)
      begin
        release_sel <= pwdata[3:0];
      end
      if (s_sw_start)
      begin
        sweep_start <= pwdata[7:0];
      end
      if (s_sw_span)
      begin
        sweep_span <= pwdata[6:0];
      end
      if (s_sw_step)
      begin
        sweep_step <= pwdata[5:0];
      end
      if (s_carrier_prop_gain_acquire)
      begin
        kp_acquire <= pwdata[3:0];
      end
      if (s_carrier_integ_gain_acquire)
      begin
        ki_acquire <= pwdata[4:0];
      end
      if (s_kp_trk)
      begin
        kp_track <= pwdata[3:0];
      end
      if (s_ki_trk)
      begin
        ki_track <= pwdata[4:0];
      end
      if (s_half_len)
      begin
        half_len <= pwdata[6:0];
      end
      // no clamp against the ffe length: software keeps it in range
      if (s_center)
      begin
        center_tap <= pwdata[7:0];
      end
      if (s_adapt)
      begin
        adapt_gains <= pwdata[7:0];
      end
      if (s_dfe_gain)
      begin
        dfe_gain <= pwdata[3:0];
      end
      if (s_eq_auto)
      begin
        eq_auto <= pwdata[1:0];
      end
      if (s_hier)
      begin
        hier_lp <= pwdata[0];
      end
      if (s_tps)
      begin
        tps_manual <= pwdata[0];
      end
    end
  end

  // kick is never stored, so the bit always reads back as 0
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      acq_restart <= 1'b0;
    end
    else
    begin
      acq_restart <= wr & s_kick & pwdata[0];
    end
  end

  // measurements move together on the core's update strobe; the lock flag is sampled every cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      m_coarse <= 12'h000;
      m_sweep <= 16'h0000;
      m_phase <= 16'h0000;
      m_cnr <= 24'h000000;
      m_noise <= 24'h000000;
      m_ref <= 14'h0000;
      m_locked <= 1'b0;
    end
    else
    begin
      m_locked <= core_stat.demod_locked;
      if (core_stat.meas_update)
      begin
        m_coarse <= core_stat.coarse_baud;
        m_sweep <= core_stat.sweep_freq;
        m_phase <= core_stat.phase_freq;
        m_cnr <= core_stat.cnr;
        m_noise <= core_stat.noise;
        m_ref <= core_stat.ref_power;
      end
    end
  end

  // power-of-two gain coding; reserved codes fall back to the automatic gain
  function automatic logic [7:0] gain_decode(input logic [3:0] code, input logic [7:0] auto_g);
    logic [7:0] g;
    g = auto_g;
    if (code != 4'h0 && code <= 4'h8)
    begin
      g = 8'h01 << (code - 4'h1);
    end
    return g;
  endfunction

  wire [1:0] baud_sel = release_sel[1:0];
  wire [1:0] tim_sel = release_sel[`QLEC_BIT_TIM_LO+:2];
  wire baud_run =
    (baud_sel == 2'b01) ? core_stat.agc_analog_lock :
    (baud_sel == 2'b10) ? core_stat.agc_all_lock :
    1'b0;
  wire tim_run =
    (tim_sel == 2'b01) ? core_stat.agc_analog_lock :
    (tim_sel == 2'b10) ? core_stat.agc_all_lock :
    (tim_sel == 2'b11) ? core_stat.baud_loop_lock :
    1'b0;
  wire self_manage = eq_auto[`QLEC_BIT_SELF];
  wire freeze_policy = eq_auto[`QLEC_BIT_POLICY];
  wire leave_full = (eq_state == QLEC_EQ_FULL) & (next_eq_state != QLEC_EQ_FULL);

  always_comb
  begin
    next_cfg = '0;
    next_cfg.baud_scan_run = baud_run;
    next_cfg.timing_loop_run = tim_run;
    next_cfg.sweep_start = sweep_start;
    next_cfg.sweep_span = sweep_span;
    next_cfg.sweep_step = sweep_step;
    next_cfg.prop_gain = m_locked ? kp_track : kp_acquire;
    next_cfg.integ_gain = m_locked ? ki_track : ki_acquire;
    next_cfg.ffe_taps = {half_len, 1'b1};
    next_cfg.center_tap = center_tap;
    next_cfg.blind_gain = gain_decode(adapt_gains[3:0], `QLEC_AUTO_BLIND);
    next_cfg.dd_ffe_gain = gain_decode(adapt_gains[7:4], `QLEC_AUTO_DD);
    next_cfg.dd_dfe_gain = gain_decode(dfe_gain, `QLEC_AUTO_DD);
    next_cfg.hier_lp = hier_lp;
    next_cfg.tps_manual = tps_manual;
  end

  // automatic sequence: blind, then decision-directed ffe, then full feedback
  always_comb
  begin
    next_eq_state = eq_state;
    unique case (eq_state)
      QLEC_EQ_BLIND:
      begin
        if (core_stat.eq_blind_conv)
        begin
          next_eq_state = QLEC_EQ_DD;
        end
      end
      QLEC_EQ_DD:
      begin
        if (core_stat.demod_locked)
        begin
          next_eq_state = QLEC_EQ_FULL;
        end
        else if (!core_stat.eq_blind_conv)
        begin
          next_eq_state = QLEC_EQ_BLIND;
        end
      end
      QLEC_EQ_FULL:
      begin
        if (!core_stat.demod_locked)
        begin
          next_eq_state = QLEC_EQ_BLIND;
        end
      end
      default:
      begin
        next_eq_state = QLEC_EQ_BLIND;
      end
    endcase
    if (!self_manage)
    begin
      next_eq_state = QLEC_EQ_BLIND;
    end
  end

  always_comb
  begin
    next_eq_cmd = '0;
    if (self_manage)
    begin
      next_eq_cmd.dd_mode = (next_eq_state != QLEC_EQ_BLIND);
      next_eq_cmd.init_dfe = leave_full & ~freeze_policy;
      next_eq_cmd.freeze_dfe = (next_eq_state != QLEC_EQ_FULL) & freeze_policy;
    end
    else
    begin
      next_eq_cmd = eq_manual_bus;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      eq_state <= QLEC_EQ_BLIND;
      loop_cfg <= '0;
      eq_cmd <= '0;
    end
    else
    begin
      eq_state <= next_eq_state;
      loop_cfg <= next_cfg;
      eq_cmd <= next_eq_cmd;
    end
  end

endmodule // qlec_regs
`default_nettype wire

// file: qlec_regs_asserts.sv
// Purpose: port-level checks on the loop/equalizer register bank
// Assumes: one pclk domain, presetn async active low
// Notes: watches ports only, bound into every qlec_regs
`include "qlec_consts.svh"
`default_nettype none
module qlec_regs_asserts
  import qlec_pkg::*;
#(
  parameter int AW = 12
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire qlec_core_stat_s core_stat,
  input wire qlec_eq_cmd_s eq_manual_bus,
  input wire qlec_cfg_s loop_cfg,
  input wire qlec_eq_cmd_s eq_cmd,
  input wire logic acq_restart
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  wire logic commit;
  assign commit = psel && penable && pready;
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_wait;
    !pready ##1 pready;
  endsequence
  a_apb_wait: assert property (s_setup ##1 penable |-> s_wait)
    else $error("access phase length wrong");
  a_ready_once: assert property (pready |=> !pready)
    else $error("pready held too long");
  a_err_rdata: assert property (commit && !pwrite && pslverr |-> prdata == 32'h0)
    else $error("refused read returned data");
  a_kick_pulse: assert property (
    commit && pwrite && pwdata[0] && paddr == `QLEC_ADDR(`QLEC_IX_KICK)
    |=> acq_restart ##1 !acq_restart) else $error("restart pulse wrong");
  a_kick_cause: assert property (acq_restart |-> $past(commit) && $past(pwrite)
    && $past(pwdata[0]) && $past(paddr) == `QLEC_ADDR(`QLEC_IX_KICK))
    else $error("restart without write");
  a_taps_write: assert property (
    commit && pwrite && paddr == `QLEC_ADDR(`QLEC_IX_HALF_LEN)
    |-> ##2 loop_cfg.ffe_taps == {$past(pwdata[6:0], 2), 1'b1}) else $error("tap count wrong");
  a_rst_dflt: assert property ($past(presetn) && !$past(presetn, 2) |->
    loop_cfg.sweep_start == `QLEC_RST_SW_START && loop_cfg.sweep_span == `QLEC_RST_SW_SPAN
    && loop_cfg.sweep_step == `QLEC_RST_SW_STEP) else $error("sweep defaults wrong");
  a_baud_gate: assert property (loop_cfg.baud_scan_run |->
    $past(core_stat.agc_analog_lock) || $past(core_stat.agc_all_lock))
    else $error("baud scan runs without agc");
  a_tim_gate: assert property (loop_cfg.timing_loop_run |->
    $past(core_stat.agc_analog_lock) || $past(core_stat.agc_all_lock)
    || $past(core_stat.baud_loop_lock)) else $error("timing loop runs without cause");
endmodule // qlec_regs_asserts
bind qlec_regs qlec_regs_asserts #(.AW(AW)) u_qlec_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .core_stat(core_stat), .eq_manual_bus(eq_manual_bus), .loop_cfg(loop_cfg),
  .eq_cmd(eq_cmd), .acq_restart(acq_restart)
);
`default_nettype wire

// file: qlec_regs_tb.sv
// Purpose: self-checking bench for the loop/equalizer register bank
// Assumes: bench is APB master and drives core status itself
// Notes: random values from a fixed seed
`include "qlec_consts.svh"
`default_nettype none
module qlec_regs_tb
  import qlec_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rdat, d;
  logic pready, pslverr, rerr, acq_restart;
  qlec_core_stat_s st = '0, cap;
  qlec_eq_cmd_s man = '0, eq_cmd;
  qlec_cfg_s loop_cfg;
  int error_cnt = 0, num_checks = 0, cyc = 0, i, k;
  logic [9:0] tix [15] = '{`QLEC_IX_RELEASE, `QLEC_IX_SW_START, `QLEC_IX_SW_SPAN,
    `QLEC_IX_SW_STEP, `QLEC_IX_CARRIER_PROP_GAIN_ACQUIRE, `QLEC_IX_CARRIER_INTEG_GAIN_ACQUIRE, `QLEC_IX_KP_TRK, `QLEC_IX_KI_TRK,
    `QLEC_IX_HALF_LEN, `QLEC_IX_CENTER, `QLEC_IX_ADAPT, `QLEC_IX_DFE_GAIN,
    `QLEC_IX_EQ_AUTO, `QLEC_IX_HIER, `QLEC_IX_TPS};
  logic [7:0] tmsk [15] = '{8'h0F, 8'hFF, 8'h7F, 8'h3F, 8'h0F, 8'h1F, 8'h0F, 8'h1F,
    8'h7F, 8'hFF, 8'hFF, 8'h0F, 8'h03, 8'h01, 8'h01};
  logic [7:0] trst [15] = '{8'h08, 8'hFA, 8'h1C, 8'h03, 8'h06, 8'h1D, 8'h05, 8'h1E,
    8'h0A, 8'h0B, 8'h00, 8'h00, 8'h03, 8'h00, 8'h00};
  logic [7:0] v [15];
  qlec_regs #(.AW(12)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .core_stat(st), .eq_manual_bus(man), .loop_cfg(loop_cfg), .eq_cmd(eq_cmd),
    .acq_restart(acq_restart)
  );
  initial
  begin
    forever #12.5 pclk = ~pclk;
  end
  task complete_run;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // whole run needs under a thousand cycles
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      error_cnt++;
      complete_run();
    end
  end
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask
  // no fixed wait: only the run timeout ends a hung access
  task apb(input logic w, input logic [9:0] ix, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {ix, 2'b00};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wt(input int c);
    repeat (c) @(posedge pclk);
    #1;
  endtask
  function logic [7:0] gexp(input logic [3:0] c, input logic [7:0] a);
    return (c == 4'h0 || c > 4'h8) ? a : 8'h01 << (c - 4'h1);
  endfunction
  function logic rexp(input logic [1:0] c, input logic [2:0] g, input logic t);
    return c == 2'h1 ? g[0] : c == 2'h2 ? g[1] : (t && c == 2'h3) ? g[2] : 1'b0;
  endfunction
  initial
  begin
    d = $urandom(32'h045E);
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    for (i = 0; i < 15; i++)
    begin
      apb(1'b0, tix[i], 32'h0);
      chk("reset value", trst[i], rdat);
      d = $urandom;
      if (i == 9)
        d = d % (2 * v[8] + 2);
      v[i] = d[7:0] & tmsk[i];
      apb(1'b1, tix[i], d);
      apb(1'b0, tix[i], 32'h0);
      chk("readback", v[i], rdat);
    end
    wt(3);
    chk("sweep start", v[1], loop_cfg.sweep_start);
    chk("sweep span", v[2], loop_cfg.sweep_span);
    chk("sweep step", v[3], loop_cfg.sweep_step);
    chk("ffe taps", {v[8][6:0], 1'b1}, loop_cfg.ffe_taps);
    chk("center tap", v[9], loop_cfg.center_tap);
    chk("hier", v[13], loop_cfg.hier_lp);
    chk("tps manual", v[14], loop_cfg.tps_manual);
    apb(1'b1, 10'h100, $urandom);
    chk("unmapped write err", 1, rerr);
    apb(1'b0, 10'h100, 32'h0);
    chk("unmapped read err", 1, rerr);
    chk("unmapped data", 0, rdat);
    for (k = 0; k < 16; k++)
    begin
      apb(1'b1, `QLEC_IX_ADAPT, {24'h0, ~k[3:0], k[3:0]});
      apb(1'b1, `QLEC_IX_DFE_GAIN, k);
      wt(3);
      chk("blind gain", gexp(k[3:0], `QLEC_AUTO_BLIND), loop_cfg.blind_gain);
      chk("dd ffe gain", gexp(~k[3:0], `QLEC_AUTO_DD), loop_cfg.dd_ffe_gain);
      chk("dd dfe gain", gexp(k[3:0], `QLEC_AUTO_DD), loop_cfg.dd_dfe_gain);
    end
    for (k = 0; k < 48; k++)
    begin
      d = $urandom;
      @(posedge pclk);
      {st.baud_loop_lock, st.agc_all_lock, st.agc_analog_lock} <= d[6:4];
      apb(1'b1, `QLEC_IX_RELEASE, {28'h0, k[3:0]});
      wt(2);
      chk("baud scan run", rexp(k[1:0], d[6:4], 1'b0), loop_cfg.baud_scan_run);
      chk("timing run", rexp(k[3:2], d[6:4], 1'b1), loop_cfg.timing_loop_run);
    end
    for (k = 0; k < 2; k++)
    begin
      @(posedge pclk);
      st.demod_locked <= k[0];
      wt(3);
      apb(1'b0, `QLEC_IX_LOCK, 32'h0);
      chk("lock flag", k, rdat);
      chk("prop gain", k ? v[6] : v[4], loop_cfg.prop_gain);
      chk("integ gain", k ? v[7] : v[5], loop_cfg.integ_gain);
    end
    // second pass changes inputs without capture: reads must not move
    for (k = 0; k < 2; k++)
    begin
      @(posedge pclk);
      st.meas_update <= (k == 0);
      {st.coarse_baud, st.sweep_freq, st.phase_freq} <= 44'({$urandom, $urandom});
      {st.cnr, st.noise, st.ref_power} <= 62'({$urandom, $urandom});
      @(posedge pclk);
      st.meas_update <= 1'b0;
      if (k == 0)
        cap = st;
      wt(2);
      apb(1'b0, `QLEC_IX_COARSE, 32'h0);
      chk("coarse baud", cap.coarse_baud, rdat);
      apb(1'b0, `QLEC_IX_SW_FREQ, 32'h0);
      chk("sweep freq", cap.sweep_freq, rdat);
      apb(1'b0, `QLEC_IX_PH_FREQ, 32'h0);
      chk("phase freq", cap.phase_freq, rdat);
      apb(1'b0, `QLEC_IX_CNR, 32'h0);
      chk("cnr", cap.cnr, rdat);
      apb(1'b0, `QLEC_IX_NOISE, 32'h0);
      chk("noise", cap.noise, rdat);
      apb(1'b0, `QLEC_IX_REF_PWR, 32'h0);
      chk("ref power", cap.ref_power, rdat);
    end
    apb(1'b1, `QLEC_IX_KICK, 32'h1);
    #1;
    chk("restart pulse", 1, acq_restart);
    apb(1'b0, `QLEC_IX_KICK, 32'h0);
    chk("kick reads idle", 0, rdat);
    apb(1'b1, `QLEC_IX_EQ_AUTO, 32'h2);
    for (k = 0; k < 8; k++)
    begin
      d = $urandom;
      @(posedge pclk);
      man <= d[4:0];
      wt(2);
      chk("manual cmd", d[4:0], eq_cmd);
    end
    @(posedge pclk);
    st.demod_locked <= 1'b0;
    st.eq_blind_conv <= 1'b0;
    apb(1'b1, `QLEC_IX_EQ_AUTO, 32'h3);
    wt(3);
    chk("blind dd mode", 0, eq_cmd.dd_mode);
    chk("blind freeze", 1, eq_cmd.freeze_dfe);
    @(posedge pclk);
    st.eq_blind_conv <= 1'b1;
    wt(3);
    @(posedge pclk);
    st.demod_locked <= 1'b1;
    wt(3);
    chk("full dd mode", 1, eq_cmd.dd_mode);
    chk("full freeze", 0, eq_cmd.freeze_dfe);
    apb(1'b1, `QLEC_IX_EQ_AUTO, 32'h1);
    st.demod_locked <= 1'b0;
    d = 32'h0;
    repeat (6)
    begin
      @(posedge pclk);
      d = d + eq_cmd.init_dfe;
    end
    chk("dfe clear pulses", 1, d);
    complete_run();
  end
endmodule // qlec_regs_tb
`default_nettype wire
